//--- pkg/ascr_defs.svh
// Offsets, field positions, reset values and codes of the slot config registers
`ifndef ASCR_DEFS_SVH
`define ASCR_DEFS_SVH

`define ASCR_ADDR_W 8
`define ASCR_DATA_W 16

`define ASCR_OFF_B_TIMING 8'h3b
`define ASCR_OFF_A_ROUTE 8'h43
`define ASCR_OFF_B_AMP 8'h44
`define ASCR_OFF_B_ROUTE 8'h45

`define ASCR_RST_B_TIMING 16'h2017
`define ASCR_RST_A_ROUTE 16'hada5
`define ASCR_RST_B_AMP 16'h1c38
`define ASCR_RST_B_ROUTE 16'hada5
`define ASCR_RST_B_WIDTH 5'h04
`define ASCR_RST_B_OFFSET 11'h017
`define ASCR_RST_B_MODE 6'h07
`define ASCR_RST_B_VREF 2'h3
`define ASCR_RST_B_GAIN 2'h0
`define ASCR_RD_ZERO 16'h0000

`define ASCR_B_WIDTH_RNG 15:11
`define ASCR_B_OFFSET_RNG 10:0
`define ASCR_B_MODE_RNG 15:10
`define ASCR_B_IGAIN_RNG 9:8
`define ASCR_B_BUF_BIT 7
`define ASCR_B_IND_BIT 6
`define ASCR_B_VREF_RNG 5:4
`define ASCR_B_RSVD_RNG 3:2
`define ASCR_B_GAIN_RNG 1:0

`define ASCR_IGAIN_C0 2'h0
`define ASCR_IGAIN_C1 2'h1
`define ASCR_IGAIN_C2 2'h2

`define ASCR_ROUTE_FULL 16'hada5
`define ASCR_ROUTE_DIRECT_BUF 16'hae65
`define ASCR_ROUTE_DIRECT 16'hb065

`define ASCR_CHANNELS 4
`define ASCR_GAIN_W 2
`define ASCR_EXT_GAIN_W 6
`define ASCR_EXT_CH4_RNG 5:4

`endif

//--- pkg/ascr_pkg.sv
// Types shared by the slot config register bank
package ascr_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } ascr_req_s;

  typedef logic [1:0] ascr_gain_t;

  typedef enum logic [3:0] {
    ASCR_PATH_FULL = 4'h1,
    ASCR_PATH_DIRECT_BUF = 4'h2,
    ASCR_PATH_DIRECT = 4'h4,
    ASCR_PATH_RSVD = 4'h8
  } ascr_path_e;

  typedef enum logic [5:0] {
    ASCR_INT_R400K = 6'h01,
    ASCR_INT_R200K = 6'h02,
    ASCR_INT_R100K = 6'h04,
    ASCR_INT_BUF_1P0 = 6'h08,
    ASCR_INT_BUF_0P7 = 6'h10,
    ASCR_INT_RSVD = 6'h20
  } ascr_igain_e;

endpackage : ascr_pkg

//--- hw/ascr_path_decode.sv
// Decodes a slot routing code into an analog path mode and a misuse flag
`timescale 1ns/1ns
`include "ascr_defs.svh"
module ascr_path_decode
  import ascr_pkg::*;
(
  input wire logic [15:0] i_code, // Routing register value
  input wire logic i_buffer_sel, // Slot integrator buffer bit
  input wire logic i_adc_buffer_en, // Converter buffer enable bit
  output ascr_path_e o_mode, // Decoded path
  output logic o_misuse // Code used without its required bits, or direct code with buffer bit set
);

  wire is_full = i_code == `ASCR_ROUTE_FULL;
  wire is_dbuf = i_code == `ASCR_ROUTE_DIRECT_BUF;
  wire is_direct = i_code == `ASCR_ROUTE_DIRECT;

  assign o_mode = is_full ? ASCR_PATH_FULL :
                  is_dbuf ? ASCR_PATH_DIRECT_BUF :
                  is_direct ? ASCR_PATH_DIRECT : ASCR_PATH_RSVD;

  // Host-side setup slips, flagged only; the path still follows the code
  assign o_misuse = (is_dbuf & ~(i_buffer_sel & i_adc_buffer_en)) |
                    (is_direct & i_buffer_sel);

endmodule : ascr_path_decode

//--- hw/ascr_slot_regs.sv
// Slot B front-end settings and slot A/B routing registers with decoded outputs
//
// Contract
// - Window width from timing bits 15:11
// - Window offset from timing bits 10:0
// - Integrator gain decode, buffer or resistor
// - Mode bit 7 turns integrator into buffer
// - Individual gain: channels 2-4 external
// - Otherwise amp gain drives all channels
// - Amp reference from bits 5:4
// - Slot B routing code selects path
// - Slot A routing register, reset full path
`timescale 1ns/1ns
`include "ascr_defs.svh"
module ascr_slot_regs
  import ascr_pkg::*;
(
  input wire logic i_clock, // 250 MHz clock
  input wire logic i_reset, // Async reset, active high
  input wire logic i_clk_en, // Freezes all state when low
  input wire ascr_req_s i_req, // Register request from serial port
  input wire logic [5:0] i_ext_gain, // Channel 2-4 gains, reg 0x55 [11:6]
  input wire logic i_a_buffer_sel, // Slot A buffer bit, reg 0x42 bit 7
  input wire logic i_adc_buffer_en, // Converter buffer bit, reg 0x58 bit 7
  output logic [15:0] o_rd_data, // Read data
  output logic o_rd_valid, // Read answer strobe
  output logic o_rd_err, // Read of unmapped address
  output logic [4:0] o_b_window_width, // Width, 1 us steps
  output logic [10:0] o_b_window_offset, // Offset, 31.25 ns steps
  output logic [5:0] o_b_front_mode_field, // Mode field as stored
  output ascr_igain_e o_b_integrator_gain, // Decoded integrator gain
  output logic o_b_integrator_buffer_sel, // Integrator as buffer
  output logic o_b_per_channel_gain_en, // Individual gains on
  output logic [1:0] o_b_amp_reference, // Amp reference code
  output ascr_gain_t [3:0] o_b_ch_gain, // Amp gain code per channel
  output ascr_path_e o_b_path_mode, // Slot B path
  output ascr_path_e o_a_path_mode, // Slot A path
  output logic o_b_route_misuse, // Slot B routing set up wrong
  output logic o_a_route_misuse // Slot A routing set up wrong
);

  logic [15:0] timing_q;
  logic [15:0] a_route_q;
  logic [15:0] amp_q;
  logic [15:0] b_route_q;

  wire hit_timing = i_req.addr == `ASCR_OFF_B_TIMING;
  wire hit_a_route = i_req.addr == `ASCR_OFF_A_ROUTE;
  wire hit_amp = i_req.addr == `ASCR_OFF_B_AMP;
  wire hit_b_route = i_req.addr == `ASCR_OFF_B_ROUTE;
  wire hit_any = hit_timing | hit_a_route | hit_amp | hit_b_route;

  wire wr_timing = i_req.wr & hit_timing;
  wire wr_a_route = i_req.wr & hit_a_route;
  wire wr_amp = i_req.wr & hit_amp;
  wire wr_b_route = i_req.wr & hit_b_route;

  wire [15:0] rd_mux = hit_timing ? timing_q :
                       hit_a_route ? a_route_q :
                       hit_amp ? amp_q :
                       hit_b_route ? b_route_q : `ASCR_RD_ZERO;

  // Storage, all bits read-write including the fixed-value fields
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      timing_q <= `ASCR_RST_B_TIMING;
      a_route_q <= `ASCR_RST_A_ROUTE;
      amp_q <= `ASCR_RST_B_AMP;
      b_route_q <= `ASCR_RST_B_ROUTE;
    end else if (i_clk_en) begin
      if (wr_timing) timing_q <= i_req.wdata;
      if (wr_a_route) a_route_q <= i_req.wdata;
      if (wr_amp) amp_q <= i_req.wdata;
      if (wr_b_route) b_route_q <= i_req.wdata;
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_rd_data <= `ASCR_RD_ZERO;
      o_rd_valid <= 1'b0;
      o_rd_err <= 1'b0;
    end else if (i_clk_en) begin
      o_rd_valid <= i_req.rd;
      o_rd_err <= i_req.rd & ~hit_any;
      if (i_req.rd) o_rd_data <= rd_mux;
    end
  end

  wire [1:0] igain_code = amp_q[`ASCR_B_IGAIN_RNG];
  wire buf_sel = amp_q[`ASCR_B_BUF_BIT];
  wire ind_en = amp_q[`ASCR_B_IND_BIT];
  wire [1:0] amp_gain = amp_q[`ASCR_B_GAIN_RNG];

  wire ascr_igain_e igain_buf = (igain_code == `ASCR_IGAIN_C2) ? ASCR_INT_BUF_0P7 :
                                ASCR_INT_BUF_1P0;
  wire ascr_igain_e igain_norm = (igain_code == `ASCR_IGAIN_C0) ? ASCR_INT_R400K :
                                 (igain_code == `ASCR_IGAIN_C1) ? ASCR_INT_R200K :
                                 ASCR_INT_R100K;
  wire igain_rsvd = igain_code > `ASCR_IGAIN_C2;
  wire ascr_igain_e igain_d = igain_rsvd ? ASCR_INT_RSVD :
                              buf_sel ? igain_buf : igain_norm;

  ascr_gain_t [3:0] ch_gain_d;
  genvar g;
  generate
    for (g = 0; g < `ASCR_CHANNELS; g = g + 1) begin : g_ch
      if (g == 0) begin : g_first
        assign ch_gain_d[g] = amp_gain;
      end else begin : g_rest
        assign ch_gain_d[g] = ind_en ? i_ext_gain[(g - 1) * `ASCR_GAIN_W +: `ASCR_GAIN_W] :
                              amp_gain;
      end
    end
  endgenerate

  ascr_path_e b_mode_d;
  ascr_path_e a_mode_d;
  logic b_misuse_d;
  logic a_misuse_d;

  ascr_path_decode u_b_path (
    .i_code(b_route_q),
    .i_buffer_sel(buf_sel),
    .i_adc_buffer_en(i_adc_buffer_en),
    .o_mode(b_mode_d),
    .o_misuse(b_misuse_d)
  );

  ascr_path_decode u_a_path (
    .i_code(a_route_q),
    .i_buffer_sel(i_a_buffer_sel),
    .i_adc_buffer_en(i_adc_buffer_en),
    .o_mode(a_mode_d),
    .o_misuse(a_misuse_d)
  );

  // Registered settings toward the slot B measurement sequence, plus slot A path and misuse
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_b_window_width <= `ASCR_RST_B_WIDTH;
      o_b_window_offset <= `ASCR_RST_B_OFFSET;
      o_b_front_mode_field <= `ASCR_RST_B_MODE;
      o_b_integrator_gain <= ASCR_INT_R400K;
      o_b_integrator_buffer_sel <= 1'b0;
      o_b_per_channel_gain_en <= 1'b0;
      o_b_amp_reference <= `ASCR_RST_B_VREF;
      o_b_ch_gain <= {`ASCR_CHANNELS{`ASCR_RST_B_GAIN}};
      o_b_path_mode <= ASCR_PATH_FULL;
      o_a_path_mode <= ASCR_PATH_FULL;
      o_b_route_misuse <= 1'b0;
      o_a_route_misuse <= 1'b0;
    end else if (i_clk_en) begin
      o_b_window_width <= timing_q[`ASCR_B_WIDTH_RNG];
      o_b_window_offset <= timing_q[`ASCR_B_OFFSET_RNG];
      o_b_front_mode_field <= amp_q[`ASCR_B_MODE_RNG];
      o_b_integrator_gain <= igain_d;
      o_b_integrator_buffer_sel <= buf_sel;
      o_b_per_channel_gain_en <= ind_en;
      o_b_amp_reference <= amp_q[`ASCR_B_VREF_RNG];
      o_b_ch_gain <= ch_gain_d;
      o_b_path_mode <= b_mode_d;
      o_a_path_mode <= a_mode_d;
      o_b_route_misuse <= b_misuse_d;
      o_a_route_misuse <= a_misuse_d;
    end
  end

  width_from_write_a: assert property (@(posedge i_clock) disable iff (i_reset)
    (wr_timing && i_clk_en ##1 i_clk_en) |=>
      o_b_window_width == $past(i_req.wdata[`ASCR_B_WIDTH_RNG], 2))
    else $error("window width not taken from written bits 15:11");

  offset_from_write_a: assert property (@(posedge i_clock) disable iff (i_reset)
    (wr_timing && i_clk_en ##1 i_clk_en) |=>
      o_b_window_offset == $past(i_req.wdata[`ASCR_B_OFFSET_RNG], 2))
    else $error("window offset not taken from written bits 10:0");

  buffer_gain_a: assert property (@(posedge i_clock) disable iff (i_reset)
    (i_clk_en && buf_sel && igain_code == `ASCR_IGAIN_C2) |=>
      o_b_integrator_gain == ASCR_INT_BUF_0P7 && o_b_integrator_buffer_sel)
    else $error("buffer code 10 did not give 0.7 gain");

  normal_gain_a: assert property (@(posedge i_clock) disable iff (i_reset)
    (i_clk_en && !buf_sel && igain_code == `ASCR_IGAIN_C1) |=>
      o_b_integrator_gain == ASCR_INT_R200K)
    else $error("normal code 01 did not give 200k");

  indiv_gain_a: assert property (@(posedge i_clock) disable iff (i_reset)
    (i_clk_en && ind_en) |=>
      o_b_ch_gain[3] == $past(i_ext_gain[`ASCR_EXT_CH4_RNG]) &&
      o_b_ch_gain[0] == $past(amp_gain))
    else $error("individual channel gains not routed");

  common_gain_a: assert property (@(posedge i_clock) disable iff (i_reset)
    (i_clk_en && !ind_en) |=>
      o_b_ch_gain[1] == $past(amp_gain) && o_b_ch_gain[2] == $past(amp_gain))
    else $error("common gain not applied to all channels");

  amp_reference_a: assert property (@(posedge i_clock) disable iff (i_reset)
    (wr_amp && i_clk_en ##1 i_clk_en) |=>
      o_b_amp_reference == $past(i_req.wdata[`ASCR_B_VREF_RNG], 2))
    else $error("amp reference not taken from bits 5:4");

  b_route_full_a: assert property (@(posedge i_clock) disable iff (i_reset)
    (wr_b_route && i_clk_en && i_req.wdata == `ASCR_ROUTE_FULL ##1 i_clk_en) |=>
      o_b_path_mode == ASCR_PATH_FULL)
    else $error("full path code not decoded");

  a_route_read_a: assert property (@(posedge i_clock) disable iff (i_reset)
    (i_clk_en && i_req.rd && hit_a_route) |=> o_rd_valid && o_rd_data == $past(a_route_q))
    else $error("slot A routing read back wrong");

  b_route_hold_a: assert property (@(posedge i_clock) disable iff (i_reset)
    !(wr_b_route && i_clk_en) |=> $stable(b_route_q))
    else $error("slot B routing changed without a write");

endmodule : ascr_slot_regs

//--- sim/ascr_host_model.sv
// Host model issuing register requests to the slot config bank
`timescale 1ns/1ns
module ascr_host_model
  import ascr_pkg::*;
(
  input wire logic i_clock, // Device clock
  output ascr_req_s o_req, // Request to the bank
  input wire logic [15:0] i_rd_data, // Read data
  input wire logic i_rd_valid, // Read answer strobe
  input wire logic i_rd_err // Unmapped read flag
);
  initial o_req = '0;

  task automatic write(input logic [7:0] a, input logic [15:0] d);
    @(negedge i_clock);
    o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge i_clock);
    o_req = '0;
    // Let the decoded outputs catch up
    @(negedge i_clock);
  endtask : write

  task automatic read(input logic [7:0] a, output logic [15:0] d, output logic e,
                      output logic ok);
    ok = 1'b0;
    d = 16'h0000;
    e = 1'b0;
    @(negedge i_clock);
    o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    // Answer stands for one cycle after the taking edge; look mid-cycle
    for (int i = 0; i < 4 && !ok; i++) begin
      @(negedge i_clock);
      o_req = '0;
      if (i_rd_valid === 1'b1) begin
        ok = 1'b1;
        d = i_rd_data;
        e = i_rd_err;
      end
    end
  endtask : read
endmodule : ascr_host_model

//--- sim/tb_ascr_slot_regs.sv
// Self-checking bench for the slot config register bank
`timescale 1ns/1ns
`include "ascr_defs.svh"
module tb_ascr_slot_regs
  import ascr_pkg::*;
;
  logic clock, reset, clk_en, a_buf, adc_buf, rd_valid, rd_err, b_ibuf, b_ind, b_mis, a_mis;
  logic [5:0] ext_gain, mode;
  logic [15:0] rd_data;
  logic [4:0] width;
  logic [10:0] offset;
  logic [1:0] vref;
  ascr_req_s req;
  ascr_igain_e igain;
  ascr_gain_t [3:0] chg;
  ascr_path_e b_path, a_path;
  int failures = 0;
  int checked = 0;

  ascr_slot_regs u_dut (.i_clock(clock), .i_reset(reset), .i_clk_en(clk_en), .i_req(req),
    .i_ext_gain(ext_gain), .i_a_buffer_sel(a_buf), .i_adc_buffer_en(adc_buf),
    .o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_rd_err(rd_err),
    .o_b_window_width(width), .o_b_window_offset(offset), .o_b_front_mode_field(mode),
    .o_b_integrator_gain(igain), .o_b_integrator_buffer_sel(b_ibuf),
    .o_b_per_channel_gain_en(b_ind), .o_b_amp_reference(vref), .o_b_ch_gain(chg),
    .o_b_path_mode(b_path), .o_a_path_mode(a_path), .o_b_route_misuse(b_mis),
    .o_a_route_misuse(a_mis));

  ascr_host_model u_host (.i_clock(clock), .o_req(req), .i_rd_data(rd_data),
    .i_rd_valid(rd_valid), .i_rd_err(rd_err));

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] a, input logic [15:0] e, input logic ee);
    logic [15:0] d;
    logic er, ok;
    u_host.read(a, d, er, ok);
    chk("read_done", 16'h1, 16'(ok));
    chk("rd_data", e, d);
    chk("rd_err", 16'(ee), 16'(er));
    if (ok !== 1'b1) end_of_test();
  endtask : rdchk

  task automatic t_reset();
    rdchk(`ASCR_OFF_B_TIMING, {5'h04, 11'h017}, 1'b0);
    rdchk(`ASCR_OFF_A_ROUTE, 16'hada5, 1'b0);
    rdchk(`ASCR_OFF_B_AMP, {6'h07, 2'h0, 2'h0, 2'h3, 2'h2, 2'h0}, 1'b0);
    rdchk(`ASCR_OFF_B_ROUTE, 16'hada5, 1'b0);
    chk("width", 16'h4, 16'(width));
    chk("offset", 16'h17, 16'(offset));
    chk("mode", 16'h7, 16'(mode));
    chk("igain", 16'(ASCR_INT_R400K), 16'(igain));
    chk("ibuf", 16'h0, 16'(b_ibuf));
    chk("ind_en", 16'h0, 16'(b_ind));
    chk("vref", 16'h3, 16'(vref));
    chk("ch_gain", 16'h0, 16'(chg));
    chk("b_path", 16'(ASCR_PATH_FULL), 16'(b_path));
    chk("a_path", 16'(ASCR_PATH_FULL), 16'(a_path));
    chk("b_misuse", 16'h0, 16'(b_mis));
    chk("a_misuse", 16'h0, 16'(a_mis));
  endtask : t_reset

  task automatic t_timing();
    u_host.write(`ASCR_OFF_B_TIMING, 16'hf801);
    chk("width", 16'h1f, 16'(width));
    chk("offset", 16'h1, 16'(offset));
    u_host.write(`ASCR_OFF_B_TIMING, 16'h07fe);
    chk("width", 16'h0, 16'(width));
    chk("offset", 16'h7fe, 16'(offset));
    rdchk(`ASCR_OFF_B_TIMING, 16'h07fe, 1'b0);
  endtask : t_timing

  task automatic t_amp();
    ascr_igain_e e;
    for (int b = 0; b < 2; b++) begin
      for (int g = 0; g < 4; g++) begin
        u_host.write(`ASCR_OFF_B_AMP, {6'h07, 2'(g), 1'(b), 3'h3, 2'h1, 2'h0});
        if (b == 1) e = g < 2 ? ASCR_INT_BUF_1P0 : g == 2 ? ASCR_INT_BUF_0P7 : ASCR_INT_RSVD;
        else e = g == 0 ? ASCR_INT_R400K : g == 1 ? ASCR_INT_R200K
          : g == 2 ? ASCR_INT_R100K : ASCR_INT_RSVD;
        chk("igain", 16'(e), 16'(igain));
        chk("ibuf", 16'(b), 16'(b_ibuf));
      end
    end
    for (int k = 0; k < 4; k++) begin
      u_host.write(`ASCR_OFF_B_AMP, {6'h07, 4'h0, 2'(k), 2'h1, 2'(k)});
      chk("vref", 16'(k), 16'(vref));
      chk("ch_gain", 16'({4{2'(k)}}), 16'(chg));
    end
    ext_gain = 6'h39;
    u_host.write(`ASCR_OFF_B_AMP, 16'h1c46);
    chk("ind_en", 16'h1, 16'(b_ind));
    chk("ch_gain", 16'h00e6, 16'(chg));
    chk("mode", 16'h7, 16'(mode));
    rdchk(`ASCR_OFF_B_AMP, 16'h1c46, 1'b0);
  endtask : t_amp

  task automatic t_route();
    logic [15:0] c[4] = '{16'hada5, 16'hae65, 16'hb065, 16'h1234};
    ascr_path_e p[4] = '{ASCR_PATH_FULL, ASCR_PATH_DIRECT_BUF, ASCR_PATH_DIRECT, ASCR_PATH_RSVD};
    a_buf = 1'b1;
    adc_buf = 1'b1;
    u_host.write(`ASCR_OFF_B_AMP, 16'h1c84);
    for (int i = 0; i < 4; i++) begin
      u_host.write(`ASCR_OFF_B_ROUTE, c[i]);
      u_host.write(`ASCR_OFF_A_ROUTE, c[i]);
      chk("b_path", 16'(p[i]), 16'(b_path));
      chk("a_path", 16'(p[i]), 16'(a_path));
      chk("b_misuse", 16'(i == 2), 16'(b_mis));
      chk("a_misuse", 16'(i == 2), 16'(a_mis));
    end
    adc_buf = 1'b0;
    u_host.write(`ASCR_OFF_B_ROUTE, 16'hae65);
    chk("b_misuse", 16'h1, 16'(b_mis));
    rdchk(`ASCR_OFF_A_ROUTE, 16'h1234, 1'b0);
  endtask : t_route

  task automatic t_misc();
    rdchk(8'h46, 16'h0000, 1'b1);
    u_host.write(8'h46, 16'h5555);
    rdchk(8'h46, 16'h0000, 1'b1);
    clk_en = 1'b0;
    u_host.write(`ASCR_OFF_B_TIMING, 16'h1234);
    clk_en = 1'b1;
    rdchk(`ASCR_OFF_B_TIMING, 16'h07fe, 1'b0);
    // Mid-run reset must bring every setting back to its default
    @(negedge clock);
    reset = 1'b1;
    @(negedge clock);
    reset = 1'b0;
    t_reset();
  endtask : t_misc

  task automatic end_of_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // Watchdog so a hang still reaches the verdict
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    $display("MISMATCH watchdog expected finish seen timeout");
    end_of_test();
  end

  initial begin
    reset = 1'b1;
    clk_en = 1'b1;
    a_buf = 1'b0;
    adc_buf = 1'b0;
    ext_gain = 6'h00;
    repeat (6) @(negedge clock);
    reset = 1'b0;
    t_reset();
    t_timing();
    t_amp();
    t_route();
    t_misc();
    end_of_test();
  end
endmodule : tb_ascr_slot_regs
